// >>> rtl/ddr_module_pkg.sv
// shared constants, command codes and state types of the memory module
package ddr_module_pkg;
  // ==========================================================
  // widths
  localparam int DQ_W = 72;
  localparam int ADDR_W = 13;
  localparam int COL_IDX = 4;
  localparam int ARR_W = 8;
  // ==========================================================
  // command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam int AP_BIT = 10;
  // ==========================================================
  // mode register layout and codes
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int OP_LSB = 7;
  localparam int DLL_BIT = 8;
  localparam logic [2:0] BL4 = 3'h2;
  localparam logic [2:0] BL8 = 3'h3;
  localparam logic [2:0] CL25 = 3'h6;
  localparam logic [2:0] CL3 = 3'h3;
  localparam logic [5:0] OP_DLL_RST = 6'h02;
  localparam logic [12:0] MODE_RST = 13'h0021;
  // self-timed precharge, link cycles after the last pair
  localparam logic [1:0] AP_CYCLES = 2'h3;
  // ==========================================================
  // presence-detect store
  localparam logic [3:0] SPD_DEV_TYPE = 4'hA;
  localparam int SPD_BYTES = 256;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // ==========================================================
  // carriers and state
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] a;
  } ddr_cmd_t;
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK} i2c_st_t;
  typedef enum logic [1:0] {K_DEV, K_WADDR, K_DATA} i2c_kind_t;
  typedef struct packed {
    logic [ADDR_W-1:0] mode;
    logic [3:0] open;
    logic [3:0][ADDR_W-1:0] row;
    logic busy;
    logic wr;
    logic ap;
    logic [1:0] bank;
    logic [COL_IDX-1:0] start;
    logic [2:0] j;
    logic [1:0] ap_cnt;
    logic [1:0] ap_bank;
    logic p1_v;
    logic [2*DQ_W-1:0] p1_d;
    logic p2_v;
    logic [2*DQ_W-1:0] p2_d;
    logic p3_v;
    logic [2*DQ_W-1:0] p3_d;
    logic p4_v;
    logic [2*DQ_W-1:0] p4_d;
    logic rise_v;
    logic rise_s;
    logic [DQ_W-1:0] rise_d;
    logic wq_v;
    logic [ARR_W-1:0] wq_i0;
    logic [ARR_W-1:0] wq_i1;
    logic w_v;
    logic [ARR_W-1:0] w_i0;
    logic [ARR_W-1:0] w_i1;
    logic dll_tgl;
  } link_state_t;
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [2:0] sa_m;
    logic [2:0] sa_s;
    logic dll_m;
    logic dll_s;
    logic dll_p;
    logic dll_pulse;
    i2c_st_t st;
    i2c_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic [7:0] ptr;
    logic oe;
  } sys_state_t;
endpackage

// >>> rtl/ddr_module.sv
// double-data-rate memory module: command side, bursts, mode register, presence store
//
// What this block does
// R1 - two words cross the pins per clock, one internal double-width fetch each cycle.
// R2 - module drives strobe on reads edge-aligned; controller strobes writes centred.
// R3 - commands sampled at every rising edge of the true clock.
// R4 - write data caught on both strobe edges; reads launched on both edges.
// R5 - controller opens a row with activate before reading or writing it.
// R6 - activate: bank bits pick one of four banks, address bits pick the row.
// R7 - read or write: bank bits pick the bank, address picks the starting column.
// R8 - burst length 2, 4 or 8, both orders, bounds columns per command.
// R9 - auto precharge closes the row self-timed after the burst ends.
// R10 - presence store holds 256 bytes, lower half factory, upper half user.
// R11 - presence store is an I2C slave; three pins give eight addresses.
// R12 - write protect is tied low, so store writes are never blocked.
// R13 - mode set with both bank bits low loads mode; held until reloaded.
// R14 - loop reset bit of the mode register clears itself after writing.
// R15 - reloading the mode register leaves the array contents untouched.
// R16 - controller loads mode only when idle, then waits before next command.
// R17 - mode bits: 0-2 length, 3 order, 4-6 latency, 7 up operating mode.
// R18 - controller must not program reserved burst length codes.
// R19 - burst wraps within an aligned block the size of the burst length.
// R20 - column bits from 1, 2 or 3 up pick the block; low bits the start.
// R21 - the same burst length serves reads and writes.
// R22 - order bit picks sequential or interleaved; order depends on start too.
// R23 - read latency 2, 2.5 or 3 clocks from the sampled read.
// R24 - operating bits zero is normal; loop reset bit alone starts loop reset.
// R25 - interleaved beat address is start low bits xor the beat count.
// R26 - controller loads the mode register before first access after power-up.
`timescale 1ns/1ps
module ddr_module
(
  // system clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // memory link
  input wire logic LINK_CLK_I,
  input wire ddr_module_pkg::ddr_cmd_t CMD_I,
  input wire logic [ddr_module_pkg::DQ_W-1:0] DQ_I,
  output logic [ddr_module_pkg::DQ_W-1:0] DQ_O,
  output logic DQ_OE_O,
  input wire logic DQS_I,
  output logic DQS_O,
  output logic DQS_OE_O,
  // presence-detect serial port
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic [2:0] PRESENCE_ADDR_PINS_I,
  // status
  output logic DLL_RESET_O
);
  import ddr_module_pkg::*;

  // ==========================================================
  // link reset release
  logic [1:0] lrst_r;
  logic lrst_n;

  always_ff @(posedge LINK_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      lrst_r <= 2'h0;
    else
      lrst_r <= {lrst_r[0], 1'b1};
  end
  assign lrst_n = lrst_r[1];

  // ==========================================================
  // burst address order
  function automatic logic [COL_IDX-1:0] colf(input logic [COL_IDX-1:0] s,
                                               input logic [2:0] k,
                                               input logic [COL_IDX-1:0] m,
                                               input logic bt);
    logic [COL_IDX-1:0] o;
    o = bt ? (s ^ {1'b0, k}) : (s + {1'b0, k}); // [R22] [R25]
    return (s & ~m) | (o & m); // [R19] [R20]
  endfunction

  // ==========================================================
  // memory array, small index: bank, row low bits, column
  logic [DQ_W-1:0] mem [0:(1<<ARR_W)-1];
  logic [DQ_W-1:0] wlo_r;
  logic [DQ_W-1:0] whi_r;

  // strobe edges clock the write words in directly
  always_ff @(posedge DQS_I)
  begin
    wlo_r <= DQ_I; // [R4] [R2]
  end

  always_ff @(negedge DQS_I)
  begin
    whi_r <= DQ_I; // [R4]
  end

  // ==========================================================
  // link domain
  link_state_t lr;
  link_state_t ln;
  logic [2:0] cmd;
  logic sel;
  logic act;
  logic a_wr;
  logic [1:0] a_bank;
  logic [COL_IDX-1:0] a_start;
  logic [2:0] a_j;
  logic [COL_IDX-1:0] bmask;
  logic [2:0] npairs;
  logic [ARR_W-1:0] idx0;
  logic [ARR_W-1:0] idx1;
  logic [1:0] rowlo;

  always_comb
  begin
    ln = lr;
    cmd = {CMD_I.ras_n, CMD_I.cas_n, CMD_I.we_n};
    sel = ~CMD_I.cs_n; // [R3]
    case (lr.mode[BL_LSB+:3]) // [R8] [R21]
      BL4: bmask = 4'h3;
      BL8: bmask = 4'h7;
      default: bmask = 4'h1;
    endcase
    npairs = bmask[3:1] + 3'h1;
    ln.mode[DLL_BIT] = 1'b0; // [R14]
    ln.w_v = 1'b0;
    // precharge countdown ends the open row
    if (lr.ap_cnt != 2'h0)
    begin
      ln.ap_cnt = lr.ap_cnt - 2'h1;
      if (lr.ap_cnt == 2'h1)
        ln.open[lr.ap_bank] = 1'b0; // [R9]
    end
    act = lr.busy;
    a_wr = lr.wr;
    a_bank = lr.bank;
    a_start = lr.start;
    a_j = lr.j;
    if (sel)
    begin
      case (cmd)
        CMD_MRS:
        begin
          // array untouched by a mode load
          if (CMD_I.ba == 2'h0) // [R13] [R15]
          begin
            ln.mode = CMD_I.a; // [R17]
            if (CMD_I.a[ADDR_W-1:OP_LSB] == OP_DLL_RST)
              ln.dll_tgl = ~lr.dll_tgl; // [R24]
          end
        end
        CMD_ACT:
        begin
          ln.open[CMD_I.ba] = 1'b1; // [R6]
          ln.row[CMD_I.ba] = CMD_I.a; // [R6]
        end
        CMD_PRE:
        begin
          if (CMD_I.a[AP_BIT])
            ln.open = 4'h0;
          else
            ln.open[CMD_I.ba] = 1'b0;
        end
        CMD_RD, CMD_WR:
        begin
          // a closed bank is ignored; a new burst cuts the old one short
          if (lr.open[CMD_I.ba]) // [R5]
          begin
            act = 1'b1;
            a_wr = (cmd == CMD_WR);
            a_bank = CMD_I.ba; // [R7]
            a_start = CMD_I.a[COL_IDX-1:0]; // [R7]
            a_j = 3'h0;
            ln.wr = a_wr;
            ln.bank = a_bank;
            ln.start = a_start;
            ln.ap = CMD_I.a[AP_BIT];
            ln.ap_cnt = 2'h0;
          end
        end
        default:
        begin
        end
      endcase
    end
    // one double-width fetch per cycle
    rowlo = lr.row[a_bank][1:0];
    idx0 = {a_bank, rowlo, colf(a_start, {a_j[1:0], 1'b0}, bmask, lr.mode[BT_BIT])}; // [R1]
    idx1 = {a_bank, rowlo, colf(a_start, {a_j[1:0], 1'b1}, bmask, lr.mode[BT_BIT])}; // [R1]
    ln.busy = act;
    if (act)
    begin
      ln.j = a_j + 3'h1;
      if (a_j + 3'h1 == npairs) // [R8]
      begin
        ln.busy = 1'b0;
        if (ln.ap)
        begin
          ln.ap_cnt = AP_CYCLES; // [R9]
          ln.ap_bank = a_bank;
        end
      end
    end
    // read pipe: stage 1 holds pair j from the edge that fetches it, the command edge for pair 0
    ln.p1_v = act & ~a_wr;
    ln.p1_d = {mem[idx1], mem[idx0]};
    ln.p2_v = lr.p1_v;
    ln.p2_d = lr.p1_d;
    ln.p3_v = lr.p2_v;
    ln.p3_d = lr.p2_d;
    ln.p4_v = lr.p3_v;
    ln.p4_d = lr.p3_d;
    // write pair lands two edges later: strobes come after the next edge
    ln.wq_v = act & a_wr;
    ln.wq_i0 = idx0;
    ln.wq_i1 = idx1;
    ln.w_v = lr.wq_v;
    ln.w_i0 = lr.wq_i0;
    ln.w_i1 = lr.wq_i1;
    case (lr.mode[CL_LSB+:3]) // [R23]
      CL3:
      begin
        ln.rise_v = lr.p3_v;
        ln.rise_s = 1'b1;
        ln.rise_d = lr.p3_d[DQ_W-1:0];
      end
      CL25:
      begin
        ln.rise_v = lr.p3_v;
        ln.rise_s = 1'b0;
        ln.rise_d = lr.p3_d[2*DQ_W-1:DQ_W];
      end
      default:
      begin
        ln.rise_v = lr.p2_v;
        ln.rise_s = 1'b1;
        ln.rise_d = lr.p2_d[DQ_W-1:0];
      end
    endcase
  end

  always_ff @(posedge LINK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      lr <= '0;
      lr.mode <= MODE_RST;
    end
    else
      lr <= ln; // [R3]
  end

  always_ff @(posedge LINK_CLK_I)
  begin
    if (lr.w_v)
    begin
      mem[lr.w_i0] <= wlo_r; // [R4]
      mem[lr.w_i1] <= whi_r;
    end
  end

  // ==========================================================
  // falling-edge half of the read launch
  logic fall_v_r;
  logic fall_s_r;
  logic [DQ_W-1:0] fall_d_r;

  always_ff @(negedge LINK_CLK_I or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      fall_v_r <= 1'b0;
      fall_s_r <= 1'b0;
      fall_d_r <= '0;
    end
    else
    begin
      case (lr.mode[CL_LSB+:3]) // [R23]
        CL3:
        begin
          fall_v_r <= lr.p4_v;
          fall_s_r <= 1'b0;
          fall_d_r <= lr.p4_d[2*DQ_W-1:DQ_W];
        end
        CL25:
        begin
          fall_v_r <= lr.p3_v;
          fall_s_r <= 1'b1;
          fall_d_r <= lr.p3_d[DQ_W-1:0];
        end
        default:
        begin
          fall_v_r <= lr.p3_v;
          fall_s_r <= 1'b0;
          fall_d_r <= lr.p3_d[2*DQ_W-1:DQ_W];
        end
      endcase
    end
  end

  // clock picks the half-cycle word; strobe toggles with each word
  assign DQ_O = LINK_CLK_I ? lr.rise_d : fall_d_r; // [R1] [R4]
  assign DQ_OE_O = LINK_CLK_I ? lr.rise_v : fall_v_r;
  assign DQS_O = LINK_CLK_I ? lr.rise_s : fall_s_r; // [R2]
  assign DQS_OE_O = DQ_OE_O; // [R2]

  // ==========================================================
  // system domain: presence store and loop reset notice
  sys_state_t sr;
  sys_state_t sn;
  logic [7:0] presence_detect_store [0:SPD_BYTES-1];
  logic spd_we;
  logic s_rise;
  logic s_fall;
  logic s_start;
  logic s_stop;

  always_comb
  begin
    sn = sr;
    spd_we = 1'b0;
    sn.scl_m = SCL_I;
    sn.scl_s = sr.scl_m;
    sn.scl_p = sr.scl_s;
    sn.sda_m = SDA_I;
    sn.sda_s = sr.sda_m;
    sn.sda_p = sr.sda_s;
    sn.sa_m = PRESENCE_ADDR_PINS_I;
    sn.sa_s = sr.sa_m;
    sn.dll_m = lr.dll_tgl;
    sn.dll_s = sr.dll_m;
    sn.dll_p = sr.dll_s;
    sn.dll_pulse = sr.dll_s ^ sr.dll_p;
    s_rise = sr.scl_s & ~sr.scl_p;
    s_fall = ~sr.scl_s & sr.scl_p;
    s_start = sr.scl_s & sr.scl_p & sr.sda_p & ~sr.sda_s;
    s_stop = sr.scl_s & sr.scl_p & ~sr.sda_p & sr.sda_s;
    if (s_start)
    begin
      sn.st = I_RX;
      sn.kind = K_DEV;
      sn.cnt = 4'h0;
      sn.oe = 1'b0;
    end
    else if (s_stop)
    begin
      sn.st = I_IDLE;
      sn.oe = 1'b0;
    end
    else
    begin
      case (sr.st)
        I_RX:
        begin
          if (s_rise)
          begin
            sn.sh = {sr.sh[6:0], sr.sda_s};
            sn.cnt = sr.cnt + 4'h1;
          end
          else if (s_fall && sr.cnt == BYTE_BITS)
          begin
            sn.st = I_ACK;
            sn.oe = 1'b1;
            case (sr.kind)
              K_DEV:
              begin
                // eight addresses from the three strap pins
                if (sr.sh[7:1] != {SPD_DEV_TYPE, sr.sa_s}) // [R11]
                begin
                  sn.st = I_IDLE;
                  sn.oe = 1'b0;
                end
                sn.rd = sr.sh[0];
              end
              K_WADDR:
                sn.ptr = sr.sh;
              default:
              begin
                // no write protect: every byte is writable
                spd_we = 1'b1; // [R12] [R10]
                sn.ptr = sr.ptr + 8'h1;
              end
            endcase
          end
        end
        I_ACK:
        begin
          if (s_fall)
          begin
            sn.cnt = 4'h0;
            if (sr.rd && sr.kind == K_DEV)
            begin
              sn.st = I_TX;
              sn.sh = presence_detect_store[sr.ptr]; // [R11]
              sn.ptr = sr.ptr + 8'h1;
              sn.oe = ~presence_detect_store[sr.ptr][7];
            end
            else
            begin
              sn.st = I_RX;
              sn.oe = 1'b0;
              sn.kind = (sr.kind == K_DEV) ? K_WADDR : K_DATA;
            end
          end
        end
        I_TX:
        begin
          if (s_rise)
            sn.cnt = sr.cnt + 4'h1;
          else if (s_fall)
          begin
            if (sr.cnt == BYTE_BITS)
            begin
              sn.st = I_TXACK;
              sn.oe = 1'b0;
            end
            else
            begin
              sn.sh = {sr.sh[6:0], 1'b0};
              sn.oe = ~sr.sh[6];
            end
          end
        end
        I_TXACK:
        begin
          // master nack ends the read
          if (s_rise && sr.sda_s)
            sn.st = I_IDLE;
          else if (s_fall)
          begin
            sn.st = I_TX;
            sn.cnt = 4'h0;
            sn.sh = presence_detect_store[sr.ptr];
            sn.ptr = sr.ptr + 8'h1;
            sn.oe = ~presence_detect_store[sr.ptr][7];
          end
        end
        default:
          sn.st = I_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      sr <= '0;
      sr.scl_m <= 1'b1;
      sr.scl_s <= 1'b1;
      sr.scl_p <= 1'b1;
      sr.sda_m <= 1'b1;
      sr.sda_s <= 1'b1;
      sr.sda_p <= 1'b1;
      sr.st <= I_IDLE;
      sr.kind <= K_DEV;
    end
    else
      sr <= sn;
  end

  // lower half carries factory data, loaded through the same port
  always_ff @(posedge SYS_CLK_I)
  begin
    if (spd_we)
      presence_detect_store[sr.ptr] <= sr.sh; // [R10]
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = sr.oe; // [R11]
  assign DLL_RESET_O = sr.dll_pulse; // [R24]
endmodule

// >>> tb/ddr_module_chk.sv
// port assertions for the memory module
`timescale 1ns/1ps
module ddr_module_chk
(
  // clocks and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  input wire logic LINK_CLK_I,
  // memory link
  input wire ddr_module_pkg::ddr_cmd_t CMD_I,
  input wire logic [ddr_module_pkg::DQ_W-1:0] DQ_I,
  input wire logic [ddr_module_pkg::DQ_W-1:0] DQ_O,
  input wire logic DQ_OE_O,
  input wire logic DQS_I,
  input wire logic DQS_O,
  input wire logic DQS_OE_O,
  // presence port and status
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic [2:0] PRESENCE_ADDR_PINS_I,
  input wire logic DLL_RESET_O
);
  import ddr_module_pkg::*;
  // ==========
  // command tracking
  logic [2:0] cl_r;
  logic [3:0] open_r;
  logic [3:0] quiet_r;
  logic dll_seen_r;
  logic sel;
  logic [2:0] op;
  logic rd_ok;
  assign sel = !CMD_I.cs_n;
  assign op = {CMD_I.ras_n, CMD_I.cas_n, CMD_I.we_n};
  // reads to closed banks are dropped, so only these may claim data
  assign rd_ok = sel && op == CMD_RD && open_r[CMD_I.ba];
  always_ff @(posedge LINK_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      cl_r <= MODE_RST[6:4];
      open_r <= 4'h0;
      quiet_r <= 4'hF;
      dll_seen_r <= 1'b0;
    end
    else
    begin
      if (sel && op == CMD_RD)
        quiet_r <= 4'h0;
      else if (quiet_r != 4'hF)
        quiet_r <= quiet_r + 4'h1;
      if (sel && op == CMD_MRS && CMD_I.ba == 2'h0)
      begin
        cl_r <= CMD_I.a[6:4];
        if (CMD_I.a[12:7] == OP_DLL_RST)
          dll_seen_r <= 1'b1;
      end
      if (sel && op == CMD_ACT)
        open_r[CMD_I.ba] <= 1'b1;
      // auto precharge closes the bank early here, only loses checks
      if (sel && (op == CMD_RD || op == CMD_WR) && CMD_I.a[AP_BIT])
        open_r[CMD_I.ba] <= 1'b0;
    end
  end
  // ==========
  // assertions
  sequence word_even;
    DQ_OE_O && DQS_O;
  endsequence
  sequence word_odd;
    DQ_OE_O && !DQS_O;
  endsequence
  strobe_follows_a: assert property (
    @(posedge LINK_CLK_I) disable iff (!RESET_N_I) DQS_OE_O == DQ_OE_O)
    else $error("strobe enable differs from data enable");
  bus_quiet_a: assert property (
    @(posedge LINK_CLK_I) disable iff (!RESET_N_I) quiet_r >= 4'h8 |-> !DQ_OE_O)
    else $error("data driven long after last read");
  lat_two_a: assert property (
    @(posedge LINK_CLK_I) disable iff (!RESET_N_I) rd_ok && cl_r == 3'h2 |-> ##3 word_odd)
    else $error("latency two read misplaced");
  lat_half_a: assert property (
    @(posedge LINK_CLK_I) disable iff (!RESET_N_I) rd_ok && cl_r == CL25 |-> ##3 word_even)
    else $error("latency two and a half read misplaced");
  lat_three_a: assert property (
    @(posedge LINK_CLK_I) disable iff (!RESET_N_I) rd_ok && cl_r == CL3 |-> ##4 word_odd)
    else $error("latency three read misplaced");
  sda_drain_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I) SDA_O == 1'b0)
    else $error("serial data driven high");
  sda_edge_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I) $changed(SDA_OE_O) |-> !SCL_I)
    else $error("serial data moved while clock high");
  dll_single_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I) DLL_RESET_O |=> !DLL_RESET_O)
    else $error("loop reset pulse too long");
  dll_cause_a: assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I) $rose(DLL_RESET_O) |-> dll_seen_r)
    else $error("loop reset without request");
endmodule
bind ddr_module ddr_module_chk chk_i
(
  .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .LINK_CLK_I(LINK_CLK_I), .CMD_I(CMD_I),
  .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O), .DQS_I(DQS_I), .DQS_O(DQS_O),
  .DQS_OE_O(DQS_OE_O), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .PRESENCE_ADDR_PINS_I(PRESENCE_ADDR_PINS_I), .DLL_RESET_O(DLL_RESET_O)
);

// >>> tb/ddr_ctrl_model.sv
// memory controller model for the link side
`timescale 1ns/1ps
module ddr_ctrl_model
(
  // link clock and read return
  input wire logic link_clk_i,
  input wire logic [ddr_module_pkg::DQ_W-1:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic dqs_i,
  // command and write path
  output ddr_module_pkg::ddr_cmd_t cmd_o,
  output logic [ddr_module_pkg::DQ_W-1:0] dq_o,
  output logic dqs_o
);
  import ddr_module_pkg::*;
  logic [73:0] q[$];
  initial
  begin
    cmd_o = {1'b1, 3'h7, 2'h0, 13'h0000};
    dq_o = {DQ_W{1'b0}};
    dqs_o = 1'b0;
  end
  // ==========
  // commands
  task automatic go(input logic [2:0] op, input logic [1:0] b, input logic [12:0] a);
    @(posedge link_clk_i);
    cmd_o <= {1'b0, op, b, a};
    @(posedge link_clk_i);
    // deselect with inverted code so a stale command never looks valid
    cmd_o <= {1'b1, ~op, b, a};
  endtask
  task automatic mrs(input logic [12:0] m);
    go(CMD_MRS, 2'h0, m);
    repeat (4) @(posedge link_clk_i);
  endtask
  // ==========
  // data phases
  task automatic wr(input logic [1:0] b, input logic [12:0] a, input int n,
    input logic [DQ_W-1:0] w[8]);
    go(CMD_WR, b, a);
    for (int j = 0; j < n; j++)
    begin
      @(posedge link_clk_i);
      dq_o <= w[2*j];
      dqs_o <= #1.5 1'b1;
      dq_o <= #3 w[2*j+1];
      dqs_o <= #4.5 1'b0;
    end
    @(posedge link_clk_i);
    dq_o <= ~w[2*n-1];
  endtask
  task automatic rd(input logic [1:0] b, input logic [12:0] a, input int n, input int hl);
    go(CMD_RD, b, a);
    repeat (hl) @(link_clk_i);
    for (int k = 0; k <= 2*n; k++)
    begin
      #1.5;
      q.push_back({dq_oe_i, dqs_i, dq_i});
      @(link_clk_i);
    end
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the memory module
`timescale 1ns/1ps
module tb_top;
  import ddr_module_pkg::*;
  typedef struct packed {logic [2:0] bl; logic bt; logic [2:0] cl; logic [2:0] hl;
    logic [3:0] st; logic [31:0] ord;} row_t;
  logic sys_clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  ddr_cmd_t cmd;
  logic [DQ_W-1:0] dq_w;
  logic [DQ_W-1:0] dq_r;
  logic dq_oe;
  logic dqs_w;
  logic dqs_r;
  logic dqs_oe;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic sda;
  logic sda_o;
  logic sda_oe;
  logic [2:0] straps = 3'h5;
  logic dll;
  logic [7:0] rx;
  logic ack;
  logic [73:0] v;
  logic [8:0] ap_pat = 9'h186;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int dll_n = 0;
  int d0;
  logic [DQ_W-1:0] mem[16];
  // ==========
  // ordinary bursts: mode, start and expected column order
  row_t rows[10] = '{
    '{3'h1, 1'b0, 3'h2, 3'h4, 4'h9, 32'h98000000},
    '{3'h1, 1'b1, 3'h2, 3'h4, 4'h4, 32'h45000000},
    '{3'h2, 1'b0, 3'h2, 3'h4, 4'h1, 32'h12300000},
    '{3'h2, 1'b1, 3'h2, 3'h4, 4'h1, 32'h10320000},
    '{3'h2, 1'b1, 3'h2, 3'h4, 4'hE, 32'hEFCD0000},
    '{3'h2, 1'b0, 3'h3, 3'h6, 4'h7, 32'h74560000},
    '{3'h3, 1'b0, 3'h2, 3'h4, 4'hD, 32'hDEF89ABC},
    '{3'h3, 1'b1, 3'h6, 3'h5, 4'h5, 32'h54761032},
    '{3'h3, 1'b1, 3'h3, 3'h6, 4'hB, 32'hBA98FEDC},
    '{3'h3, 1'b0, 3'h6, 3'h5, 4'h6, 32'h67012345}};
  // open-drain wire with pull-up
  assign sda = sda_m & ~(sda_oe & ~sda_o);
  always #4 sys_clk = ~sys_clk;
  always #3 lclk = ~lclk;
  ddr_module dut
  (
    .SYS_CLK_I(sys_clk), .RESET_N_I(rst_n), .LINK_CLK_I(lclk), .CMD_I(cmd),
    .DQ_I(dq_w), .DQ_O(dq_r), .DQ_OE_O(dq_oe), .DQS_I(dqs_w), .DQS_O(dqs_r),
    .DQS_OE_O(dqs_oe), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .PRESENCE_ADDR_PINS_I(straps), .DLL_RESET_O(dll)
  );
  ddr_ctrl_model ctl
  (
    .link_clk_i(lclk), .dq_i(dq_r), .dq_oe_i(dq_oe), .dqs_i(dqs_r),
    .cmd_o(cmd), .dq_o(dq_w), .dqs_o(dqs_w)
  );
  // ==========
  // checking and closing
  task automatic chk(input logic [73:0] got, input logic [73:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (dll)
      dll_n <= dll_n + 1;
    if (cyc == 30000)
    begin
      mismatches++;
      close_out();
    end
  end
  // ==========
  // burst helpers
  task automatic wr_b(input logic [3:0] st, input logic [31:0] ord, input logic [7:0] s,
    input int n);
    logic [DQ_W-1:0] w[8];
    for (int k = 0; k < 8; k++)
    begin
      w[k] = {9{s ^ {4'h0, ord[31-4*k -: 4]}}};
      if (k < n)
        mem[ord[31-4*k -: 4]] = w[k];
    end
    ctl.wr(2'h0, {9'h000, st}, n / 2, w);
  endtask
  task automatic rd_b(input row_t r, input logic ld);
    int n;
    n = 1 << r.bl;
    if (ld)
      ctl.mrs({6'h00, r.cl, r.bt, r.bl});
    ctl.rd(2'h0, {9'h000, r.st}, n / 2, r.hl);
    for (int k = 0; k < n; k++)
    begin
      v = ctl.q.pop_front();
      chk(v, {1'b1, ~k[0], mem[r.ord[31-4*k -: 4]]});
    end
    v = ctl.q.pop_front();
    chk({73'h0, v[73]}, 74'h0);
  endtask
  // ==========
  // serial port helpers, every change on a system clock edge
  task automatic hold;
    repeat (10) @(posedge sys_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    hold();
    scl <= 1'b1;
    hold();
    r = sda;
    scl <= 1'b0;
    hold();
  endtask
  task automatic start;
    sda_m <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_m <= 1'b0;
    hold();
    scl <= 1'b0;
    hold();
  endtask
  task automatic stop;
    sda_m <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda_m <= 1'b1;
    hold();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], r[i]);
    bit_io(1'b1, a);
  endtask
  task automatic put(input logic [7:0] b, input logic ea);
    xfer(b, rx, ack);
    chk({73'h0, ack}, {73'h0, ea});
  endtask
  // ==========
  // main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge lclk);
    ctl.go(CMD_ACT, 2'h0, 13'h0000);
    ctl.go(CMD_ACT, 2'h2, 13'h0001);
    ctl.mrs(13'h0023);
    wr_b(4'h0, 32'h01234567, 8'h11, 8);
    wr_b(4'h8, 32'h89ABCDEF, 8'h11, 8);
    ctl.mrs(13'h0029);
    wr_b(4'h5, 32'h54000000, 8'h22, 2);
    for (int r = 0; r < 10; r++)
      rd_b(rows[r], 1'b1);
    ctl.mrs(13'h0021);
    ctl.rd(2'h2, 13'h0400, 1, 4);
    repeat (6) @(posedge lclk);
    ctl.rd(2'h2, 13'h0000, 1, 4);
    ctl.go(CMD_ACT, 2'h2, 13'h0001);
    ctl.rd(2'h2, 13'h0000, 1, 4);
    for (int k = 0; k < 9; k++)
    begin
      v = ctl.q.pop_front();
      chk({73'h0, v[73]}, {73'h0, ap_pat[8-k]});
    end
    d0 = dll_n;
    ctl.mrs(13'h0123);
    repeat (8) @(posedge lclk);
    chk(74'(dll_n - d0), 74'h1);
    ctl.mrs(13'h0023);
    repeat (8) @(posedge lclk);
    chk(74'(dll_n - d0), 74'h1);
    ctl.go(CMD_MRS, 2'h1, 13'h0032);
    rd_b(rows[6], 1'b0);
    start();
    put({SPD_DEV_TYPE, 3'h5, 1'b0}, 1'b0);
    put(8'h90, 1'b0);
    put(8'h5A, 1'b0);
    stop();
    start();
    put({SPD_DEV_TYPE, 3'h5, 1'b0}, 1'b0);
    put(8'h90, 1'b0);
    start();
    put({SPD_DEV_TYPE, 3'h5, 1'b1}, 1'b0);
    xfer(8'hFF, rx, ack);
    chk({66'h0, rx}, 74'h5A);
    stop();
    start();
    put({SPD_DEV_TYPE, 3'h2, 1'b0}, 1'b1);
    stop();
    close_out();
  end
endmodule
